// ### logic/code_lock_pkg.sv
// constants and carrier types shared by the code protection block
package code_lock_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] status_off = 12'h004;
  localparam logic [11:0] addr_off = 12'h008;
  localparam logic [11:0] wdata_off = 12'h00C;
  localparam logic [11:0] vdata_off = 12'h010;
  localparam logic [11:0] fetch_off = 12'h014;
  localparam logic [11:0] fdata_off = 12'h018;

  // ----------------------------------------------------------------------
  // control command field positions
  // ----------------------------------------------------------------------
  localparam int cmd_pgm_code_pos = 0;
  localparam int cmd_pgm_key_pos = 1;
  localparam int cmd_pgm_lock1_pos = 2;
  localparam int cmd_pgm_lock2_pos = 3;
  localparam int cmd_verify_pos = 4;
  localparam int cmd_fetch_pos = 5;
  localparam int ctrl_ext_pos = 6;

  // ----------------------------------------------------------------------
  // sizes, reset values, timing
  // ----------------------------------------------------------------------
  localparam int code_aw = 13;
  localparam int key_depth = 64;
  localparam int key_aw = 6;
  localparam logic [7:0] key_reset = 8'hFF;
  localparam logic [31:0] zero_word = 32'h0000_0000;
  localparam int clk_mhz = 40;
  localparam int osc_mhz_max = 6;
  localparam int verify_osc_periods = 48;
  // tightest limit: 48 periods at the fastest oscillator
  localparam int verify_cycles =
    (verify_osc_periods * clk_mhz) / osc_mhz_max;
  localparam logic [8:0] verify_cnt_max = 9'(verify_cycles);

  // ----------------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic lock_bit_one;
    logic lock_bit_two;
    logic key_done;
    logic ext_latched;
  } lock_state_s;

  typedef enum logic [1:0] {st_idle, st_wait, st_done} verify_e;

endpackage : code_lock_pkg

// ### logic/code_rom_security_lock.sv
// program memory protection: lock bits, key array, verify and fetch gating
// Operation
// R1 - unlocked part returns code on verify
// R2 - programmed key makes verify output encrypted
// R3 - lock one blocks external table reads
// R4 - lock one latches pin, stops programming
// R5 - both locks also disable verify
// R6 - key array of 64 bytes, erased ones
// R7 - undefined lock combinations never relied on
// R8 - programmer sets lock two after one
// R9 - small image: code then locks at 1040
// R10 - large image: code then locks at 2040
// R11 - key bytes follow user code in image
// R12 - strobe high at least 10 us
// R13 - verify data valid within 48 periods
// R14 - encrypted byte is code xnor key
// R15 - key array never readable
// R16 - five 100 us strobe pulses per location
// R17 - programmer gives address, reads data port
// R18 - key byte chosen by low six address bits
// R19 - lock state loaded at reset, held
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
module code_rom_security_lock (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // nonvolatile lock field and external fetch pin
  input wire logic [1:0] lock_field,
  input wire logic external_fetch_select_pin,
  // code memory port
  input wire logic [7:0] code_rdata,
  output logic [12:0] code_addr,
  output logic [7:0] code_wdata,
  output logic code_wr,
  // protection state
  output code_lock_pkg::lock_state_s lock_state,
  output logic fetch_blocked
);
  import code_lock_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic lock1_ff;
  logic lock2_ff;
  logic key_done_ff;
  logic ext_ff;
  logic load_ff;
  logic [2:0] pin_sync_ff;
  logic pin_q_ff;
  logic [12:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] vdata_ff;
  logic [7:0] fdata_ff;
  logic vvalid_ff;
  logic fvalid_ff;
  logic refused_ff;
  logic fblk_ff;
  logic [8:0] vcnt_ff;
  verify_e vst_ff;
  verify_e nxt_vst;
  logic [7:0] key_byte;
  logic ext_mode_ff;

  // ----------------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------------
  wire wr_cyc = psel && penable && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  wire hit_ctrl = paddr == ctrl_off;
  wire hit_status = paddr == status_off;
  wire hit_addr = paddr == addr_off;
  wire hit_wdata = paddr == wdata_off;
  wire hit_vdata = paddr == vdata_off;
  wire hit_fetch = paddr == fetch_off;
  wire hit_fdata = paddr == fdata_off;
  wire hit_any = hit_ctrl || hit_status || hit_addr || hit_wdata
    || hit_vdata || hit_fetch || hit_fdata;
  wire ctrl_wr = wr_cyc && hit_ctrl;
  wire go_code = ctrl_wr && pwdata[cmd_pgm_code_pos];
  wire go_key = ctrl_wr && pwdata[cmd_pgm_key_pos];
  wire go_lock1 = ctrl_wr && pwdata[cmd_pgm_lock1_pos];
  wire go_lock2 = ctrl_wr && pwdata[cmd_pgm_lock2_pos];
  wire go_verify = ctrl_wr && pwdata[cmd_verify_pos];
  wire go_fetch = ctrl_wr && pwdata[cmd_fetch_pos];

  // ----------------------------------------------------------------------
  // protection decisions
  // ----------------------------------------------------------------------
  // lock two without lock one is undefined; treated as fully locked
  wire lock_any = lock1_ff || lock2_ff; // R7
  wire verify_ok = !lock2_ff; // R5
  wire pgm_ok = !lock_any; // R4
  wire code_pgm = go_code && pgm_ok; // R4
  wire key_pgm = go_key && pgm_ok; // R4
  wire pgm_refused = (go_code || go_key) && !pgm_ok;
  wire verify_refused = go_verify && !verify_ok; // R5
  // with a lock bit set, a table read from external code space cannot see internal bytes
  wire ext_fetch = ext_mode_ff || (lock_any ? ext_ff : pin_q_ff);
  // a command counts as external if its own source bit or the pin (latched level once locked, live level while open) says so
  wire cmd_ext = pwdata[ctrl_ext_pos] || (lock_any ? ext_ff : pin_q_ff);
  wire fetch_denied = go_fetch && lock_any && cmd_ext; // R3
  wire [5:0] key_sel = addr_ff[key_aw-1:0]; // R18
  // xnor with the selected key byte, raw when key array is erased
  wire [7:0] verify_byte =
    key_done_ff ? ~(code_rdata ^ key_byte) : code_rdata; // R2 R14

  // ----------------------------------------------------------------------
  // key array
  // ----------------------------------------------------------------------
  // its read port only feeds the xnor, so keys never reach the bus
  key_mem u_key_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(key_pgm),
    .wr_addr(addr_ff[key_aw-1:0]),
    .wr_data(wdata_ff),
    .rd_addr(key_sel),
    .rd_data(key_byte)
  ); // R15

  // ----------------------------------------------------------------------
  // lock state load and hold
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_ff <= 1'b1;
      lock1_ff <= 1'b0;
      lock2_ff <= 1'b0;
      key_done_ff <= 1'b0;
      ext_ff <= 1'b0;
    end else begin
      load_ff <= 1'b0;
      if (load_ff) begin
        lock1_ff <= lock_field[0]; // R19
        lock2_ff <= lock_field[1]; // R19
        ext_ff <= pin_q_ff; // R4
      end else begin
        lock1_ff <= lock1_ff | go_lock1;
        // a second lock bit is still allowed after the first
        lock2_ff <= lock2_ff | go_lock2;
      end
      key_done_ff <= key_done_ff | key_pgm; // R2
    end
  end

  // ----------------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------------
  // no reset on purpose: the chain keeps sampling while reset is held,
  // so the level latched at the first edge after release is settled
  always_ff @(posedge pclk) begin
    pin_sync_ff <= {pin_sync_ff[1:0], external_fetch_select_pin};
  end

  // a change counts once the last two stages agree
  wire pin_agree = pin_sync_ff[1] == pin_sync_ff[2];
  always_ff @(posedge pclk) begin
    if (pin_agree) begin
      pin_q_ff <= pin_sync_ff[2];
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff <= 13'h0000;
      wdata_ff <= 8'h00;
      ext_mode_ff <= 1'b0;
    end else begin
      if (wr_cyc && hit_addr) begin
        addr_ff <= pwdata[code_aw-1:0];
      end
      if (wr_cyc && hit_wdata) begin
        wdata_ff <= pwdata[7:0];
      end
      if (ctrl_wr) begin
        ext_mode_ff <= pwdata[ctrl_ext_pos];
      end
    end
  end

  // ----------------------------------------------------------------------
  // verify sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_vst = vst_ff;
    case (vst_ff)
      st_idle: begin
        if ((go_verify && verify_ok) || go_fetch) begin
          nxt_vst = st_wait;
        end
      end
      st_wait: begin
        nxt_vst = st_done;
      end
      default: begin
        nxt_vst = st_idle;
      end
    endcase
  end

  logic is_fetch_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vst_ff <= st_idle;
      is_fetch_ff <= 1'b0;
      vdata_ff <= 8'h00;
      fdata_ff <= 8'h00;
      vvalid_ff <= 1'b0;
      fvalid_ff <= 1'b0;
      fblk_ff <= 1'b0;
      refused_ff <= 1'b0;
    end else begin
      vst_ff <= nxt_vst;
      if (vst_ff == st_idle && go_fetch) begin
        is_fetch_ff <= 1'b1;
      end else if (vst_ff == st_idle && go_verify) begin
        is_fetch_ff <= 1'b0;
      end
      if (go_verify) begin
        vvalid_ff <= 1'b0;
      end
      if (vst_ff == st_done && !is_fetch_ff) begin
        vdata_ff <= verify_byte; // R1 R13
        vvalid_ff <= 1'b1;
      end
      if (go_fetch) begin
        fvalid_ff <= 1'b0;
        fblk_ff <= fetch_denied; // R3
      end else if (vst_ff == st_done && is_fetch_ff) begin
        fdata_ff <= fblk_ff ? 8'h00 : code_rdata; // R3
        fvalid_ff <= 1'b1;
      end
      if (ctrl_wr) begin
        refused_ff <= pgm_refused || verify_refused;
      end
    end
  end

  // ----------------------------------------------------------------------
  // verify latency counter
  // ----------------------------------------------------------------------
  // flags an answer slower than the fastest programmer may wait for;
  // kept apart so the sequencer block stays short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcnt_ff <= 9'h000;
    end else if (go_verify) begin
      vcnt_ff <= 9'h000;
    end else if (vst_ff == st_wait && !vvalid_ff) begin
      vcnt_ff <= vcnt_ff + 9'h001;
    end
  end

  // ----------------------------------------------------------------------
  // read mux and outputs
  // ----------------------------------------------------------------------
  wire [31:0] status_word = {22'h0, vcnt_ff >= verify_cnt_max,
    fblk_ff, refused_ff, fvalid_ff, vvalid_ff, ext_fetch, key_done_ff,
    ext_ff, lock2_ff, lock1_ff};
  wire [31:0] rd_word =
    hit_status ? status_word :
    hit_addr ? {19'h0, addr_ff} :
    hit_wdata ? {24'h0, wdata_ff} :
    hit_vdata ? {24'h0, vdata_ff} :
    hit_fdata ? {24'h0, fdata_ff} :
    hit_ctrl ? {25'h0, ext_mode_ff, 6'h00} : zero_word;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= zero_word;
      pready <= 1'b0;
      pslverr <= 1'b0;
      code_addr <= 13'h0000;
      code_wdata <= 8'h00;
      code_wr <= 1'b0;
      lock_state <= '0;
      fetch_blocked <= 1'b0;
    end else begin
      // registered at setup, so every access is answered with no wait
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit_any;
      prdata <= rd_setup ? rd_word : zero_word;
      code_addr <= addr_ff;
      code_wdata <= wdata_ff;
      code_wr <= code_pgm; // R4
      lock_state <= '{lock1_ff, lock2_ff, key_done_ff, ext_ff};
      fetch_blocked <= lock_any && ext_fetch; // R3
    end
  end

endmodule : code_rom_security_lock

// ### logic/key_mem.sv
// 64 byte encryption key array, registered read
`timescale 1ns/1ps
module key_mem (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // write port
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [7:0] wr_data,
  // read port
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data
);
  import code_lock_pkg::*;

  logic [7:0] mem_ff [key_depth];

  // ----------------------------------------------------------------------
  // storage, all ones until programmed
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < key_depth; gi++) begin : g_ent
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mem_ff[gi] <= key_reset; // R6
        end else if (wr_en && wr_addr == 6'(gi)) begin
          mem_ff[gi] <= mem_ff[gi] & wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= key_reset;
    end else begin
      rd_data <= mem_ff[rd_addr];
    end
  end

endmodule : key_mem

// ### sim/code_lock_properties.sv
// protection checker: apb answer, lock gating and code port timing
`timescale 1ns/1ps
module code_lock_props (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // protection side
  input wire logic [12:0] code_addr,
  input wire logic code_wr,
  input wire code_lock_pkg::lock_state_s lock_state,
  input wire logic fetch_blocked
);
  import code_lock_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire locked = lock_state.lock_bit_one | lock_state.lock_bit_two;
  wire acc = psel & penable & pready;
  wire [12:0] wd13 = pwdata[12:0];
  // ------
  // steps
  // ------
  sequence setup_s; psel && !penable; endsequence
  sequence addr_wr_s; acc && pwrite && paddr == addr_off; endsequence
  sequence pgm_s;
    acc && pwrite && paddr == ctrl_off && pwdata[cmd_pgm_code_pos];
  endsequence
  // ------
  // rules
  // ------
  setup_answer_a: assert property (setup_s |=> pready)
    else $error("no ready after setup");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  err_zero_a: assert property (pslverr |-> pready && !(|prdata))
    else $error("refused access returned data");
  lock_one_hold_a: assert property (
    lock_state.lock_bit_one |=> lock_state.lock_bit_one)
    else $error("lock one dropped");
  lock_two_hold_a: assert property (
    lock_state.lock_bit_two |=> lock_state.lock_bit_two)
    else $error("lock two dropped");
  locked_no_write_strobe_a: assert property (
    locked && $past(locked) |-> !code_wr)
    else $error("programming while locked");
  write_strobe_pulse_a: assert property (pgm_s and !locked |-> ##[1:2] code_wr)
    else $error("unlocked program gave no write");
  addr_follow_a: assert property (
    addr_wr_s |-> ##2 code_addr == $past(wd13, 2))
    else $error("code address does not follow");
  fetch_block_a: assert property (fetch_blocked |-> locked)
    else $error("table read blocked while open");
endmodule : code_lock_props

bind code_rom_security_lock code_lock_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .code_addr(code_addr),
  .code_wr(code_wr), .lock_state(lock_state),
  .fetch_blocked(fetch_blocked)
);

// ### sim/code_mem_model.sv
// code memory model standing behind the protection block
`timescale 1ns/1ps
module code_mem_model (
  // clock
  input wire logic pclk,
  // code port
  input wire logic [12:0] code_addr,
  input wire logic [7:0] code_wdata,
  input wire logic code_wr,
  output logic [7:0] code_rdata
);
  logic [7:0] mem_ff [0:8191];
  // a fixed pattern, so the bench can predict unwritten bytes
  initial begin
    for (int i = 0; i < 8192; i++) begin
      mem_ff[i] = 8'(i * 7);
    end
  end
  assign code_rdata = mem_ff[code_addr];
  always @(posedge pclk) begin
    if (code_wr) begin
      mem_ff[code_addr] <= code_wdata;
    end
  end
endmodule : code_mem_model

// ### sim/code_rom_security_lock_tb_top.sv
// bench: programs, verifies, locks and reads the protection block
`timescale 1ns/1ps
module code_rom_security_lock_tb_top;
  import code_lock_pkg::*;
  typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} note_s;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [1:0] lock_field = 2'b00;
  logic external_fetch_select_pin = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, code_wr, fetch_blocked;
  logic [12:0] code_addr, a, b;
  logic [7:0] code_wdata, code_rdata, d, k;
  lock_state_s lock_state;
  logic [7:0] img [logic [12:0]];
  note_s notes[$];
  note_s nt;
  int err_count = 0;
  int samples_checked = 0;
  always #12.5 pclk = ~pclk;
  code_rom_security_lock dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lock_field(lock_field),
    .external_fetch_select_pin(external_fetch_select_pin),
    .code_rdata(code_rdata), .code_addr(code_addr),
    .code_wdata(code_wdata), .code_wr(code_wr), .lock_state(lock_state),
    .fetch_blocked(fetch_blocked));
  code_mem_model u_mem (.pclk(pclk), .code_addr(code_addr),
    .code_wdata(code_wdata), .code_wr(code_wr), .code_rdata(code_rdata));
  // ------
  // apb master and result watcher
  // ------
  task automatic xfer(input logic w, input logic [11:0] ad,
      input logic [31:0] wd, input logic [31:0] ex, input logic [31:0] m,
      input logic er);
    note_s n = '{ex, m, er};
    notes.push_back(n);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the watchdog ends a hung wait
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    xfer(1'b1, ad, wd, '0, '0, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] ad, input logic [31:0] ex,
      input logic [31:0] m);
    xfer(1'b0, ad, '0, ex, m, 1'b0);
  endtask : rd
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
      nt = notes.pop_front();
      samples_checked++;
      if ((prdata & nt.mask) !== nt.exp || pslverr !== nt.err) begin
        err_count++;
        $display("MISMATCH prdata at %h exp %h/%b got %h/%b", paddr, nt.exp,
          nt.err, prdata & nt.mask, pslverr);
      end
    end
  end
  // ------
  // helpers
  // ------
  function automatic logic [7:0] code_of(input logic [12:0] ad);
    return img.exists(ad) ? img[ad] : 8'(ad * 7);
  endfunction : code_of
  task automatic pgm(input logic [12:0] ad, input logic [7:0] v,
      input logic [31:0] c);
    wr(addr_off, 32'(ad));
    wr(wdata_off, 32'(v));
    repeat (5) wr(ctrl_off, c);
  endtask : pgm
  // command then fixed settle: the answer lands two cycles after it
  task automatic cmd_rd(input logic [12:0] ad, input logic [31:0] c,
      input logic [11:0] off, input logic [7:0] ex);
    wr(addr_off, 32'(ad));
    wr(ctrl_off, c);
    repeat (3) @(posedge pclk);
    rd(off, 32'(ex), 32'h0000_00FF);
  endtask : cmd_rd
  // pin set long before release, past its synchroniser
  task automatic do_reset(input logic [1:0] lf, input logic pin);
    presetn <= 1'b0;
    lock_field <= lf;
    external_fetch_select_pin <= pin;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask : do_reset
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  // ------
  // scenarios
  // ------
  initial begin
    #100us;
    err_count++;
    conclude();
  end
  initial begin
    void'($urandom(32'h9ACD_6629));
    do_reset(2'b00, 1'b0);
    rd(status_off, '0, 32'h0000_000F);
    xfer(1'b0, 12'h01C, '0, '0, 32'hFFFF_FFFF, 1'b1);
    for (int i = 0; i < 4; i++) begin
      a = 13'($urandom);
      d = 8'($urandom);
      pgm(a, d, 32'h01);
      img[a] = d;
      cmd_rd(a, 32'h10, vdata_off, d);
    end
    a = 13'($urandom);
    k = 8'($urandom);
    pgm(a, k, 32'h02);
    for (int i = 0; i < 3; i++) begin
      b = {7'($urandom), a[5:0]};
      cmd_rd(b, 32'h10, vdata_off, ~(code_of(b) ^ k));
    end
    b = a ^ 13'h0001;
    cmd_rd(b, 32'h60, fdata_off, code_of(b));
    wr(ctrl_off, 32'h04);
    pgm(b, ~code_of(b), 32'h01);
    rd(status_off, 32'h0000_0081, 32'h0000_0081);
    cmd_rd(b, 32'h10, vdata_off, code_of(b));
    cmd_rd(b, 32'h60, fdata_off, 8'h00);
    rd(status_off, 32'h0000_0100, 32'h0000_0100);
    cmd_rd(b, 32'h20, fdata_off, code_of(b));
    wr(ctrl_off, 32'h08);
    wr(ctrl_off, 32'h10);
    rd(status_off, 32'h0000_0083, 32'h0000_0083);
    do_reset(2'b11, 1'b1);
    rd(status_off, 32'h0000_0017, 32'h0000_0017);
    do_reset(2'b10, 1'b0);
    pgm(b, 8'h00, 32'h01);
    rd(status_off, 32'h0000_0080, 32'h0000_0080);
    do_reset(2'b01, 1'b0);
    external_fetch_select_pin <= 1'b1;
    cmd_rd(b, 32'h20, fdata_off, code_of(b));
    conclude();
  end
endmodule : code_rom_security_lock_tb_top
